// ---- rtl/wwd_watchdog.sv ----
// Windowed watchdog timer core
`timescale 1ns/1ps
module wwd_watchdog
    import wwd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Watchdog clock sources as one-cycle enables
    input  wire logic        rc_tick,
    input  wire logic        osc_tick,
    input  wire wwd_clksel_t clk_sel,
    // Configuration and control
    input  wire wwd_cfg_t    cfg,
    input  wire logic        enable_req,
    input  wire logic        reset_en_req,
    input  wire logic        feed_valid,
    input  wire logic [7:0]  feed_data,
    input  wire logic        timeout_clr,
    input  wire logic        warn_clr,
    input  wire logic        wdreset_clr,
    // Status and events
    output wwd_stat_t        stat,
    output logic             wd_int,
    output logic             wd_reset_out
);
    wwd_feed_t   feed_st_r;
    logic        en_r;
    logic        rst_en_r;
    logic [23:0] cnt_r;
    logic        tmo_flag_r;
    logic        warn_flag_r;
    logic        wdrst_flag_r;
    logic        wdrst_r;
    logic        wd_tick;
    logic        dec_tick;
    logic        feed_ok;
    logic        feed_bad;
    logic        fault;
    logic        expire;
    logic [23:0] load_val;

    // Clock source choice
    assign wd_tick = (clk_sel == WWD_CLK_OSC) ? osc_tick : rc_tick;

    wwd_prescaler #(.DIV(WWD_PRESCALE)) u_pre (
        .clk      (clk),
        .reset    (reset),
        .clr      (!en_r),
        .tick_in  (wd_tick),
        .tick_out (dec_tick)
    );

    // Short time-outs are clamped so the period never drops under 256 ticks
    assign load_val = (cfg.timeout < WWD_TC_MIN) ? WWD_TC_MIN : cfg.timeout;

    // Feed sequence: first word then second word on the very next cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            feed_st_r <= WWD_FEED_IDLE;
        end else if (feed_valid && feed_st_r == WWD_FEED_IDLE && feed_data == WWD_FEED_1ST) begin
            feed_st_r <= WWD_FEED_HALF;
        end else begin
            feed_st_r <= WWD_FEED_IDLE;
        end
    end

    assign feed_ok  = feed_valid && feed_st_r == WWD_FEED_HALF && feed_data == WWD_FEED_2ND;
    // Broken pair: second half missing, wrong, or a stray word
    assign feed_bad = (feed_st_r == WWD_FEED_HALF && !feed_ok)
                   || (feed_valid && feed_st_r == WWD_FEED_IDLE && feed_data != WWD_FEED_1ST);
    // A good feed while the count is still above the window is too early
    assign fault  = en_r && (feed_bad || (feed_ok && cnt_r > cfg.window));
    assign expire = en_r && dec_tick && cnt_r == 24'h000000;

    // Enable and reset option are sticky; software has no way to clear them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_r     <= 1'b0;
            rst_en_r <= 1'b0;
        end else begin
            if ((expire || fault) && !rst_en_r) begin
                en_r <= 1'b0;
            end else if (enable_req) begin
                en_r <= 1'b1;
            end
            if (reset_en_req) begin
                rst_en_r <= 1'b1;
            end
        end
    end

    // 24-bit down-counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= WWD_TC_RST;
        end else if ((enable_req && !en_r) || (en_r && feed_ok && !fault)) begin
            cnt_r <= load_val;
        end else if (en_r && dec_tick && cnt_r != 24'h000000) begin
            cnt_r <= cnt_r - 24'h000001;
        end
    end

    // Sticky flags; a set in the clear cycle wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmo_flag_r  <= 1'b0;
            warn_flag_r <= 1'b0;
        end else begin
            if ((expire || fault) && !rst_en_r) begin
                tmo_flag_r <= 1'b1;
            end else if (timeout_clr) begin
                tmo_flag_r <= 1'b0;
            end
            if (en_r && dec_tick && cnt_r == cfg.warn + 24'h000001) begin
                warn_flag_r <= 1'b1;
            end else if (warn_clr) begin
                warn_flag_r <= 1'b0;
            end
        end
    end

    // Chip reset request and record of its cause
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wdrst_r      <= 1'b0;
            wdrst_flag_r <= 1'b0;
        end else begin
            wdrst_r <= (expire || fault) && rst_en_r;
            if ((expire || fault) && rst_en_r) begin
                wdrst_flag_r <= 1'b1;
            end else if (wdreset_clr) begin
                wdrst_flag_r <= 1'b0;
            end
        end
    end

    assign wd_reset_out      = wdrst_r;
    assign wd_int            = tmo_flag_r || warn_flag_r;
    // One driver for the whole status word
    assign stat              = '{en_r, tmo_flag_r, warn_flag_r, wdrst_flag_r, cnt_r};
endmodule : wwd_watchdog

// ---- rtl/wwd_pkg.sv ----
// Windowed watchdog constants and carrier types
// Contract
// - Enabled watchdog resets the chip unless reloaded before the time-out elapses.
// - With window selected, a reload above the window value is a fault.
// - Warning interrupt flags when the counter reaches the programmed warning value.
// - Software can enable; only hardware reset or watchdog event disables.
// - A wrong feed sequence causes reset, or interrupt when reset is off.
// - Readable flag set when the watchdog caused the chip reset.
// - Time-out counter is a 24-bit down-counter behind a prescaler.
// - Time-out spans 256 to 2^24 ticks of four watchdog clocks.
// - Watchdog clock selects internal RC or dedicated watchdog oscillator.
// - Watchdog reset output is one of the chip reset sources.
package wwd_pkg;
    localparam int          WWD_CNT_W     = 24;
    localparam int          WWD_PRESCALE  = 4;
    localparam logic [23:0] WWD_TC_MIN    = 24'h0000ff;
    localparam logic [23:0] WWD_TC_RST    = 24'h0000ff;
    localparam logic [23:0] WWD_WIN_RST   = 24'hffffff;
    localparam logic [23:0] WWD_WARN_RST  = 24'h000000;
    localparam logic [7:0]  WWD_FEED_1ST  = 8'haa;
    localparam logic [7:0]  WWD_FEED_2ND  = 8'h55;

    typedef enum logic [1:0] {
        WWD_CLK_RC  = 2'b00,
        WWD_CLK_OSC = 2'b01
    } wwd_clksel_t;

    typedef enum logic [1:0] {
        WWD_FEED_IDLE = 2'b00,
        WWD_FEED_HALF = 2'b01
    } wwd_feed_t;

    typedef struct packed {
        logic        reset_en;
        logic [23:0] timeout;
        logic [23:0] window;
        logic [23:0] warn;
    } wwd_cfg_t;

    typedef struct packed {
        logic        enabled;
        logic        timeout_flag;
        logic        warn_flag;
        logic        wdreset_flag;
        logic [23:0] count;
    } wwd_stat_t;
endpackage : wwd_pkg

// ---- rtl/wwd_prescaler.sv ----
// Divide-by-N enable divider for the watchdog clock ticks
`timescale 1ns/1ps
module wwd_prescaler
    import wwd_pkg::*;
#(
    parameter int DIV = WWD_PRESCALE
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Ticks
    input  wire logic clr,
    input  wire logic tick_in,
    output logic      tick_out
);
    localparam int          CW   = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (clr) begin
            cnt_r <= '0;
        end else if (tick_in) begin
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        end
    end

    assign tick_out = tick_in && (cnt_r == LAST);
endmodule : wwd_prescaler

// ---- testbench/wwd_watchdog_asserts.sv ----
// Assertion checker for the windowed watchdog core
`timescale 1ns/1ps
module wwd_watchdog_asserts
    import wwd_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Stimulus
    input wire logic       rc_tick,
    input wire logic       osc_tick,
    input wire wwd_cfg_t   cfg,
    input wire logic       enable_req,
    input wire logic       feed_valid,
    input wire logic [7:0] feed_data,
    input wire logic       timeout_clr,
    input wire logic       wdreset_clr,
    // Results
    input wire wwd_stat_t  stat,
    input wire logic       wd_int,
    input wire logic       wd_reset_out
);
    wire logic [23:0] t_eff = (cfg.timeout < WWD_TC_MIN) ? WWD_TC_MIN : cfg.timeout;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence good_feed;
        stat.enabled && feed_valid && feed_data == WWD_FEED_1ST
        ##1 feed_valid && feed_data == WWD_FEED_2ND && stat.count < cfg.window;
    endsequence
    sequence at_zero;
        stat.enabled && stat.count == 24'h000000 && rc_tick && osc_tick && !feed_valid
        && !timeout_clr && !wdreset_clr;
    endsequence
    enable_load_a: assert property (enable_req && !stat.enabled |=> stat.enabled && stat.count == t_eff)
        else $error("enable did not load the time-out");
    enable_hold_a: assert property ($fell(stat.enabled) |-> stat.timeout_flag)
        else $error("enable dropped without a watchdog event");
    feed_load_a: assert property (good_feed |=> stat.count == t_eff)
        else $error("valid feed did not reload");
    bad_feed_a: assert property (stat.enabled && feed_valid && feed_data != WWD_FEED_1ST
        && feed_data != WWD_FEED_2ND |-> ##[1:2] (wd_reset_out || stat.timeout_flag))
        else $error("wrong feed word not punished");
    prescale_a: assert property (!feed_valid && stat.enabled && $past(stat.enabled)
        && stat.count == $past(stat.count) - 24'h1 ##1 !feed_valid |-> $stable(stat.count))
        else $error("count stepped faster than the prescaler");
    expiry_a: assert property (at_zero [*4] |-> ##[1:2] (stat.wdreset_flag || stat.timeout_flag))
        else $error("expiry not signalled");
    warn_set_a: assert property (stat.enabled && $past(stat.count) == cfg.warn + 24'h1
        && stat.count == cfg.warn |-> ##[0:1] stat.warn_flag)
        else $error("warning flag missed");
    int_line_a: assert property (wd_int == (stat.timeout_flag || stat.warn_flag))
        else $error("interrupt line disagrees with flags");
    rst_pulse_a: assert property (wd_reset_out |-> stat.wdreset_flag ##1 !wd_reset_out)
        else $error("reset pulse or its flag wrong");
endmodule : wwd_watchdog_asserts

bind wwd_watchdog wwd_watchdog_asserts i_chk (.clk, .reset, .rc_tick, .osc_tick, .cfg, .enable_req,
    .feed_valid, .feed_data, .timeout_clr, .wdreset_clr, .stat, .wd_int, .wd_reset_out);

// ---- testbench/testbench.sv ----
// Self-checking bench for the windowed watchdog core
`timescale 1ns/1ps
module testbench;
    import wwd_pkg::*;
    logic        clk, reset, rc_tick, osc_tick, enable_req, reset_en_req, feed_valid, rnd;
    logic        timeout_clr, warn_clr, wdreset_clr, wd_int, wd_reset_out;
    logic [7:0]  feed_data, d;
    logic [31:0] lfsr = 32'h7a2940c3;
    wwd_clksel_t clk_sel;
    wwd_cfg_t    cfg;
    wwd_stat_t   stat;
    int          fails, n_tests, n;
    wwd_watchdog i_dut (.clk, .reset, .rc_tick, .osc_tick, .clk_sel, .cfg, .enable_req, .reset_en_req,
        .feed_valid, .feed_data, .timeout_clr, .warn_clr, .wdreset_clr, .stat, .wd_int, .wd_reset_out);
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic feed(input logic [7:0] w);
        @(posedge clk);
        feed_valid <= 1'b1;
        feed_data  <= w;
    endtask : feed
    task automatic idle;
        @(posedge clk);
        {feed_valid, enable_req, reset_en_req, timeout_clr, warn_clr, wdreset_clr} <= '0;
        #1;
    endtask : idle
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Random gaps in the ticks stretch time-out without breaking the prescaler rules
    always @(posedge clk) begin
        lfsr     <= nxt(lfsr);
        rc_tick  <= !rnd | lfsr[3];
        osc_tick <= !rnd | lfsr[9];
    end
    initial begin
        #160000;
        fails++;
        end_sim();
    end
    initial begin
        {fails, n_tests, rnd, reset, feed_data} = '0;
        {enable_req, reset_en_req, feed_valid, timeout_clr, warn_clr, wdreset_clr} = '0;
        reset = 1'b1;
        clk_sel = WWD_CLK_RC;
        cfg = '{1'b0, 24'h000120, 24'hffffff, 24'h000010};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1 chk({stat.enabled, stat.count}, 32'h000000ff);
        @(posedge clk) enable_req <= 1'b1;
        idle();
        chk(stat.count, 24'h000120);
        feed(WWD_FEED_1ST);
        feed(WWD_FEED_2ND);
        idle();
        chk(stat.count, 24'h000120);
        while (!stat.warn_flag && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        chk({wd_int, stat.count}, 32'h01000010);
        n = 0;
        while (!stat.timeout_flag && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n, 68);
        chk({stat.enabled, wd_reset_out}, 2'b00);
        @(posedge clk) {timeout_clr, warn_clr, reset_en_req, enable_req} <= 4'hf;
        idle();
        chk(wd_int, 1'b0);
        d = (lfsr[7:0] == 8'haa || lfsr[7:0] == 8'h55) ? 8'h3c : lfsr[7:0];
        feed(d);
        idle();
        chk({stat.wdreset_flag, stat.enabled}, 2'b11);
        @(posedge clk) wdreset_clr <= 1'b1;
        cfg.window <= 24'h000020;
        idle();
        feed(WWD_FEED_1ST);
        feed(WWD_FEED_2ND);
        idle();
        chk(stat.wdreset_flag, 1'b1);
        n = 0;
        while (stat.count >= 24'h00001c && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        feed(WWD_FEED_1ST);
        feed(WWD_FEED_2ND);
        idle();
        chk(stat.count, 24'h000120);
        rnd <= 1'b1;
        clk_sel <= WWD_CLK_OSC;
        repeat (300) @(posedge clk);
        reset <= 1'b1;
        #1 chk({stat.enabled, stat.wdreset_flag, wd_reset_out}, 3'b000);
        end_sim();
    end
endmodule : testbench
